//--- src/eeprom_cfg_safety_volatile_regs.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Config/safety read loops; drive bits change only from second status-write byte.
// - Two nonvolatile drive bits at config 6:5 set read output impedance.
// - Code 01 medium, 10 low; 00/11 forbidden to host; medium at delivery.
// - Config bit 0 locks identification page read-only when set.
// - Lock bit changes only with a two-byte status-write.
// - Safety byte is eight volatile read-only flags, looped, cleared by clear-flags.
// - Bit 7 sticky protected-modify flag; cleared by clear-flags, power-up, soft reset.
// - Bit 6 power-up outcome, refreshed at power-up and soft reset.
// - Power-up failure flag set makes main status read all ones.
// - Bit 5 last erase result; cleared by power-up, clear-flags, soft reset.
// - Bit 4 last program result; sticky while buffer mode is on.
// - Bit 3 single-bit correction during last read, program or write.
// - Bit 2 double-bit correction during last read, program or write.
// - Bit 1 triple-bit detection in any 16-byte word, refreshed per operation.
// - Bit 0 sticky triple-bit detection copy, cleared only by clear/reset.
// - ECC flags accumulate within one operation; several may be set.
// - Volatile byte: bit 1 buffer-mode enable, bit 0 buffer full, looped read.
// - Enable set by write-enable then volatile-write; allows buffering during program.
// - Enable off blocks page-program decode while busy; cleared at reset.
// - Buffer full discards incoming page-program commands while busy.
// - Buffer full set at power-up, drops on enable write, forced while disabled.
// - 512-byte read-only discoverable-parameter table via its read command.
// - First status-write byte goes to main status; second to config.
module eeprom_cfg_safety_volatile_regs (
   // Core clock and power-up reset
   input wire logic clock,
   input wire logic rst_b,
   // Serial link
   input wire logic sck,
   input wire logic cs_b,
   input wire logic mosi,
   output logic miso_o,
   output logic miso_oe,
   // Engine state and events, core clock
   input wire logic busy,
   input wire logic wel,
   input wire logic status_wr_allowed,
   input wire logic [7:0] status_in,
   input wire logic pu_result_valid,
   input wire logic pu_result_err,
   input wire logic sw_reset,
   input wire logic protect_violation,
   input wire logic erase_done,
   input wire logic erase_err,
   input wire logic prog_done,
   input wire logic prog_err,
   input wire logic op_start,
   input wire logic ecc_single,
   input wire logic ecc_double,
   input wire logic ecc_triple,
   input wire logic buf_taken,
   input wire logic buf_freed,
   // Configuration and control outputs
   output logic [1:0] drive_strength,
   output logic idpage_lock,
   output logic buffer_mode_on,
   output logic buffer_full,
   output logic pp_decode_allow,
   output logic [7:0] safety_flags,
   output logic [7:0] status_view,
   output logic status_wr_pulse,
   output logic [7:0] status_wr_data
);

   function automatic logic [7:0] sfdp_byte(input logic [eeprom_regs_pkg::SFDP_AW-1:0] a);
      logic [7:0] b;
      b = 8'hFF;
      case (a)
         9'h000: b = 8'h53;
         9'h001: b = 8'h46;
         9'h002: b = 8'h44;
         9'h003: b = 8'h50;
         9'h004: b = 8'h06;
         9'h005: b = 8'h01;
         9'h006: b = 8'h00;
         9'h007: b = 8'hFF;
         default: b = 8'hFF;
      endcase
      return b;
   endfunction : sfdp_byte

   // ---------------- Core domain register bank ----------------
   logic [1:0] drv_q, drv_d;
   logic lock_q, lock_d;
   logic [7:0] saf_q, saf_d;
   logic bufon_q, bufon_d;
   logic full_q, full_d;
   logic stw_q, stw_d;
   logic [7:0] stdat_q, stdat_d;
   logic ev_s1_q, ev_s2_q, ev_s3_q;
   logic ev_fire;
   // Event handshake from link side
   logic ev_tgl_q, ev_tgl_d;
   eeprom_regs_pkg::ev_kind_t ev_kind_q, ev_kind_d;
   logic [7:0] ev_data_q, ev_data_d;

   assign ev_fire = ev_s2_q ^ ev_s3_q;

   always_comb begin
      drv_d = drv_q;
      lock_d = lock_q;
      saf_d = saf_q;
      bufon_d = bufon_q;
      full_d = full_q;
      stw_d = 1'b0;
      stdat_d = stdat_q;
      if (sw_reset) begin
         saf_d = SAFETY_RESET_KEEP_PUF(saf_q);
         bufon_d = eeprom_regs_pkg::BUFON_RESET;
      end
      if (ev_fire) begin
         case (ev_kind_q)
            eeprom_regs_pkg::EV_CLEAR: begin
               saf_d = eeprom_regs_pkg::SAFETY_RESET;
            end
            eeprom_regs_pkg::EV_STATUS: begin
               if (status_wr_allowed) begin
                  stw_d = 1'b1;
                  stdat_d = ev_data_q;
               end
            end
            eeprom_regs_pkg::EV_CFG: begin
               if (status_wr_allowed) begin
                  drv_d = ev_data_q[eeprom_regs_pkg::CFG_DRV_LO+:2];
                  lock_d = lock_q | ev_data_q[eeprom_regs_pkg::CFG_IDLOCK];
               end
            end
            eeprom_regs_pkg::EV_VOL: begin
               if (wel) begin
                  bufon_d = ev_data_q[eeprom_regs_pkg::VOL_BUFON];
                  if (ev_data_q[eeprom_regs_pkg::VOL_BUFON]) begin
                     full_d = 1'b0;
                  end
               end
            end
            default: begin
               saf_d = saf_d;
            end
         endcase
      end
      // Hardware events after clears so a same-cycle set survives
      // power-up outcome refresh
      if (pu_result_valid) begin
         saf_d[eeprom_regs_pkg::SF_PUF] = pu_result_err;
      end
      if (protect_violation) begin
         saf_d[eeprom_regs_pkg::SF_PROT] = 1'b1;
      end
      if (erase_done) begin
         saf_d[eeprom_regs_pkg::SF_ERF] = erase_err;
      end
      if (prog_done) begin
         saf_d[eeprom_regs_pkg::SF_PRF] = bufon_q ? (saf_d[eeprom_regs_pkg::SF_PRF] | prog_err) : prog_err;
      end
      if (op_start) begin
         saf_d[eeprom_regs_pkg::SF_SCORR] = 1'b0;
         saf_d[eeprom_regs_pkg::SF_DCORR] = 1'b0;
         saf_d[eeprom_regs_pkg::SF_TDET] = 1'b0;
      end
      if (ecc_single) begin
         saf_d[eeprom_regs_pkg::SF_SCORR] = 1'b1;
      end
      if (ecc_double) begin
         saf_d[eeprom_regs_pkg::SF_DCORR] = 1'b1;
      end
      if (ecc_triple) begin
         saf_d[eeprom_regs_pkg::SF_TDET] = 1'b1;
         saf_d[eeprom_regs_pkg::SF_TDETS] = 1'b1;
      end
      if (buf_freed) begin
         full_d = 1'b0;
      end
      if (buf_taken) begin
         full_d = 1'b1;
      end
      if (!bufon_d) begin
         full_d = 1'b1;
      end
   end

   // Keeps the power-up outcome, which the soft reset refresh rewrites
   function automatic logic [7:0] SAFETY_RESET_KEEP_PUF(input logic [7:0] s);
      logic [7:0] r;
      r = eeprom_regs_pkg::SAFETY_RESET;
      r[eeprom_regs_pkg::SF_PUF] = s[eeprom_regs_pkg::SF_PUF];
      return r;
   endfunction : SAFETY_RESET_KEEP_PUF

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         drv_q <= eeprom_regs_pkg::DRV_RESET;
         lock_q <= eeprom_regs_pkg::IDLOCK_RESET;
         saf_q <= eeprom_regs_pkg::SAFETY_RESET;
         bufon_q <= eeprom_regs_pkg::BUFON_RESET;
         full_q <= eeprom_regs_pkg::BUFFULL_RESET;
         stw_q <= 1'b0;
         stdat_q <= 8'h00;
         ev_s1_q <= 1'b0;
         ev_s2_q <= 1'b0;
         ev_s3_q <= 1'b0;
      end else begin
         drv_q <= drv_d;
         lock_q <= lock_d;
         saf_q <= saf_d;
         bufon_q <= bufon_d;
         full_q <= full_d;
         stw_q <= stw_d;
         stdat_q <= stdat_d;
         ev_s1_q <= ev_tgl_q;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   assign drive_strength = drv_q;
   assign idpage_lock = lock_q;
   assign buffer_mode_on = bufon_q;
   assign buffer_full = full_q;
   assign safety_flags = saf_q;
   assign pp_decode_allow = !busy || (bufon_q && !full_q);
   assign status_view = saf_q[eeprom_regs_pkg::SF_PUF] ? eeprom_regs_pkg::STATUS_FAIL_VIEW : status_in;
   assign status_wr_pulse = stw_q;
   assign status_wr_data = stdat_q;

   // ---------------- Snapshot handshake toward link ----------------
   logic [7:0] snap_cfg_q, snap_cfg_d, snap_saf_q, snap_saf_d, snap_vol_q, snap_vol_d;
   logic snap_tgl_q, snap_tgl_d;
   logic ack_s1_q, ack_s2_q;
   logic seen_q, seen_d;

   // Reloads only once the link side acknowledged; the link clock may stall
   always_comb begin
      snap_cfg_d = snap_cfg_q;
      snap_saf_d = snap_saf_q;
      snap_vol_d = snap_vol_q;
      snap_tgl_d = snap_tgl_q;
      if (snap_tgl_q == ack_s2_q) begin
         snap_cfg_d = 8'h00;
         snap_cfg_d[eeprom_regs_pkg::CFG_DRV_LO+:2] = drv_q;
         snap_cfg_d[eeprom_regs_pkg::CFG_IDLOCK] = lock_q;
         snap_saf_d = saf_q;
         snap_vol_d = {6'h00, bufon_q, full_q};
         snap_tgl_d = !snap_tgl_q;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         snap_cfg_q <= 8'h00;
         snap_saf_q <= 8'h00;
         snap_vol_q <= 8'h00;
         snap_tgl_q <= 1'b0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         snap_cfg_q <= snap_cfg_d;
         snap_saf_q <= snap_saf_d;
         snap_vol_q <= snap_vol_d;
         snap_tgl_q <= snap_tgl_d;
         ack_s1_q <= seen_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // ---------------- Link domain, persistent ----------------
   logic sn_s1_q, sn_s2_q;
   logic [7:0] m_cfg_q, m_cfg_d, m_saf_q, m_saf_d, m_vol_q, m_vol_d;
   logic ev_go;
   eeprom_regs_pkg::ev_kind_t ev_kind_n;
   logic [7:0] ev_data_n;

   always_comb begin
      seen_d = seen_q;
      m_cfg_d = m_cfg_q;
      m_saf_d = m_saf_q;
      m_vol_d = m_vol_q;
      if (sn_s2_q != seen_q) begin
         m_cfg_d = snap_cfg_q;
         m_saf_d = snap_saf_q;
         m_vol_d = snap_vol_q;
         seen_d = sn_s2_q;
      end
      ev_tgl_d = ev_go ? !ev_tgl_q : ev_tgl_q;
      ev_kind_d = ev_go ? ev_kind_n : ev_kind_q;
      ev_data_d = ev_go ? ev_data_n : ev_data_q;
   end

   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         sn_s1_q <= 1'b0;
         sn_s2_q <= 1'b0;
         seen_q <= 1'b0;
         m_cfg_q <= 8'h00;
         m_saf_q <= 8'h00;
         m_vol_q <= 8'h00;
         ev_tgl_q <= 1'b0;
         ev_kind_q <= eeprom_regs_pkg::EV_CLEAR;
         ev_data_q <= 8'h00;
      end else begin
         sn_s1_q <= snap_tgl_q;
         sn_s2_q <= sn_s1_q;
         seen_q <= seen_d;
         m_cfg_q <= m_cfg_d;
         m_saf_q <= m_saf_d;
         m_vol_q <= m_vol_d;
         ev_tgl_q <= ev_tgl_d;
         ev_kind_q <= ev_kind_d;
         ev_data_q <= ev_data_d;
      end
   end

   // ---------------- Link domain, per frame ----------------
   eeprom_regs_pkg::spi_state_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] op_q, op_d, sh_q, sh_d, rx, out_byte;
   logic [1:0] idx_q, idx_d;
   logic [eeprom_regs_pkg::SFDP_AW-1:0] ptr_q, ptr_d;
   logic miso_q, miso_d, reading;

   assign rx = {sh_q[6:0], mosi};

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 3'h1;
      sh_d = rx;
      op_d = op_q;
      idx_d = idx_q;
      ptr_d = ptr_q;
      ev_go = 1'b0;
      ev_kind_n = eeprom_regs_pkg::EV_CLEAR;
      ev_data_n = rx;
      if (cnt_q == 3'h7) begin
         case (st_q)
            eeprom_regs_pkg::ST_OPCODE: begin
               op_d = rx;
               idx_d = 2'h0;
               case (rx)
                  eeprom_regs_pkg::OP_WRITE_STATUS_CFG, eeprom_regs_pkg::OP_WRITE_VOLATILE,
                  eeprom_regs_pkg::OP_READ_CFG_SAFETY, eeprom_regs_pkg::OP_READ_VOLATILE: begin
                     st_d = eeprom_regs_pkg::ST_DATA;
                  end
                  eeprom_regs_pkg::OP_READ_SFDP: begin
                     st_d = eeprom_regs_pkg::ST_ADDR;
                  end
                  eeprom_regs_pkg::OP_CLEAR_FLAGS: begin
                     ev_go = 1'b1;
                     st_d = eeprom_regs_pkg::ST_IGNORE;
                  end
                  default: begin
                     st_d = eeprom_regs_pkg::ST_IGNORE;
                  end
               endcase
            end
            eeprom_regs_pkg::ST_ADDR: begin
               idx_d = idx_q + 2'h1;
               if (idx_q == eeprom_regs_pkg::SFDP_DUMMY_IDX) begin
                  st_d = eeprom_regs_pkg::ST_DATA;
               end else begin
                  ptr_d = {ptr_q[0], rx};
               end
            end
            eeprom_regs_pkg::ST_DATA: begin
               idx_d = idx_q + 2'h1;
               ptr_d = ptr_q + 9'h001;
               if (op_q == eeprom_regs_pkg::OP_WRITE_STATUS_CFG) begin
                  ev_go = 1'b1;
                  ev_kind_n = (idx_q == 2'h0) ? eeprom_regs_pkg::EV_STATUS : eeprom_regs_pkg::EV_CFG;
                  if (idx_q != 2'h0) begin
                     st_d = eeprom_regs_pkg::ST_IGNORE;
                  end
               end else if (op_q == eeprom_regs_pkg::OP_WRITE_VOLATILE) begin
                  ev_go = 1'b1;
                  ev_kind_n = eeprom_regs_pkg::EV_VOL;
                  st_d = eeprom_regs_pkg::ST_IGNORE;
               end
            end
            default: begin
               st_d = eeprom_regs_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // Frame logic restarts whenever the host deselects
   always_ff @(posedge sck or posedge cs_b) begin
      if (cs_b) begin
         st_q <= eeprom_regs_pkg::ST_OPCODE;
         cnt_q <= 3'h0;
         op_q <= 8'h00;
         sh_q <= 8'h00;
         idx_q <= 2'h0;
         ptr_q <= 9'h000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         sh_q <= sh_d;
         idx_q <= idx_d;
         ptr_q <= ptr_d;
      end
   end

   always_comb begin
      out_byte = 8'h00;
      reading = 1'b0;
      if (st_q == eeprom_regs_pkg::ST_DATA) begin
         case (op_q)
            eeprom_regs_pkg::OP_READ_CFG_SAFETY: begin
               out_byte = idx_q[0] ? m_saf_q : m_cfg_q;
               reading = 1'b1;
            end
            eeprom_regs_pkg::OP_READ_VOLATILE: begin
               out_byte = m_vol_q;
               reading = 1'b1;
            end
            eeprom_regs_pkg::OP_READ_SFDP: begin
               out_byte = sfdp_byte(ptr_q);
               reading = 1'b1;
            end
            default: begin
               out_byte = 8'h00;
            end
         endcase
      end
      miso_d = out_byte[3'h7 - cnt_q];
   end

   // Output changes on the falling edge so the host samples on the rising
   always_ff @(negedge sck or posedge cs_b) begin
      if (cs_b) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= miso_d;
      end
   end

   assign miso_o = miso_q;
   assign miso_oe = !cs_b && reading;

endmodule : eeprom_cfg_safety_volatile_regs
`default_nettype wire

//--- src/eeprom_regs_pkg.sv
`default_nettype none
package eeprom_regs_pkg;
   // Instruction codes
   localparam logic [7:0] OP_WRITE_STATUS_CFG = 8'h01;
   localparam logic [7:0] OP_READ_CFG_SAFETY = 8'h15;
   localparam logic [7:0] OP_READ_VOLATILE = 8'h85;
   localparam logic [7:0] OP_WRITE_VOLATILE = 8'h81;
   localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
   localparam logic [7:0] OP_READ_SFDP = 8'h5A;
   // Configuration byte fields
   localparam int CFG_DRV_LO = 5;
   localparam int CFG_IDLOCK = 0;
   localparam logic [1:0] DRV_MEDIUM = 2'h1;
   localparam logic [1:0] DRV_LOW = 2'h2;
   localparam logic [1:0] DRV_RESET = DRV_MEDIUM;
   localparam logic IDLOCK_RESET = 1'h0;
   // Safety byte fields
   localparam int SF_PROT = 7;
   localparam int SF_PUF = 6;
   localparam int SF_ERF = 5;
   localparam int SF_PRF = 4;
   localparam int SF_SCORR = 3;
   localparam int SF_DCORR = 2;
   localparam int SF_TDET = 1;
   localparam int SF_TDETS = 0;
   localparam logic [7:0] SAFETY_RESET = 8'h00;
   localparam logic [7:0] STATUS_FAIL_VIEW = 8'hFF;
   // Volatile byte fields
   localparam int VOL_BUFON = 1;
   localparam int VOL_BUFFULL = 0;
   localparam logic BUFON_RESET = 1'h0;
   localparam logic BUFFULL_RESET = 1'h1;
   // Discoverable-parameter table
   localparam int SFDP_BYTES = 512;
   localparam int SFDP_AW = 9;
   localparam logic [1:0] SFDP_DUMMY_IDX = 2'h3;
   typedef enum logic [1:0] {EV_STATUS, EV_CFG, EV_VOL, EV_CLEAR} ev_kind_t;
   typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} spi_state_t;
endpackage : eeprom_regs_pkg
`default_nettype wire

//--- test/eeprom_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_regs_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Core inputs
   input wire logic busy,
   input wire logic [7:0] status_in,
   input wire logic pu_result_valid,
   input wire logic pu_result_err,
   input wire logic sw_reset,
   input wire logic protect_violation,
   input wire logic erase_done,
   input wire logic erase_err,
   input wire logic prog_done,
   input wire logic prog_err,
   input wire logic op_start,
   input wire logic ecc_single,
   input wire logic ecc_double,
   input wire logic ecc_triple,
   // Watched outputs
   input wire logic buffer_mode_on,
   input wire logic buffer_full,
   input wire logic pp_decode_allow,
   input wire logic [7:0] safety_flags,
   input wire logic [7:0] status_view
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   property p_fail_view; status_view == (safety_flags[6] ? 8'hFF : status_in); endproperty
   a_fail_view: assert property (p_fail_view) else $error("status view mismatch");
   property p_pp_gate; pp_decode_allow == (!busy || (buffer_mode_on && !buffer_full)); endproperty
   a_pp_gate: assert property (p_pp_gate) else $error("decode gate mismatch");
   property p_full_forced; !buffer_mode_on && !$past(buffer_mode_on) |-> buffer_full; endproperty
   a_full_forced: assert property (p_full_forced) else $error("buffer full not forced");
   property p_prot; protect_violation |=> safety_flags[7] [*2]; endproperty
   a_prot: assert property (p_prot) else $error("protect flag not held");
   property p_pu; pu_result_valid |=> safety_flags[6] == $past(pu_result_err); endproperty
   a_pu: assert property (p_pu) else $error("power-up flag wrong");
   property p_erase; erase_done |=> safety_flags[5] == $past(erase_err); endproperty
   a_erase: assert property (p_erase) else $error("erase flag wrong");
   property p_prog; prog_done |=> safety_flags[4] ==
      ($past(prog_err) || ($past(buffer_mode_on) && $past(safety_flags[4]))); endproperty
   a_prog: assert property (p_prog) else $error("program flag wrong");
   property p_corr; (ecc_single || ecc_double) |=> (safety_flags[3] || !$past(ecc_single))
      && (safety_flags[2] || !$past(ecc_double)); endproperty
   a_corr: assert property (p_corr) else $error("correction flag missing");
   property p_triple; ecc_triple |=> safety_flags[1] && safety_flags[0]; endproperty
   a_triple: assert property (p_triple) else $error("triple flags missing");
   property p_refresh; op_start && !(ecc_single || ecc_double || ecc_triple)
      |=> safety_flags[3:0] == {3'h0, $past(safety_flags[0])}; endproperty
   a_refresh: assert property (p_refresh) else $error("refresh wrong");
   property p_soft; sw_reset && !protect_violation
      |=> !safety_flags[7] && !buffer_mode_on && buffer_full; endproperty
   a_soft: assert property (p_soft) else $error("soft reset wrong");
   c_buffered: cover property (busy && buffer_mode_on && pp_decode_allow);
   c_fail_view: cover property (safety_flags[6] && status_view == 8'hFF);
   c_sticky: cover property (prog_done && buffer_mode_on && safety_flags[4]);
endmodule : eeprom_regs_chk
bind eeprom_cfg_safety_volatile_regs eeprom_regs_chk i_chk (
   .clock(clock), .rst_b(rst_b), .busy(busy), .status_in(status_in),
   .pu_result_valid(pu_result_valid), .pu_result_err(pu_result_err), .sw_reset(sw_reset),
   .protect_violation(protect_violation), .erase_done(erase_done), .erase_err(erase_err),
   .prog_done(prog_done), .prog_err(prog_err), .op_start(op_start), .ecc_single(ecc_single),
   .ecc_double(ecc_double), .ecc_triple(ecc_triple), .buffer_mode_on(buffer_mode_on),
   .buffer_full(buffer_full), .pp_decode_allow(pp_decode_allow), .safety_flags(safety_flags),
   .status_view(status_view)
);
`default_nettype wire

//--- test/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   // Serial link
   output logic sck,
   output logic cs_b,
   output logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe
);
   // Non-blocking so the frame reset edge is not lost at time zero
   initial begin
      sck <= 1'b0;
      cs_b <= 1'b1;
      mosi <= 1'b0;
   end
   // Link clock stands still between frames
   task automatic frame(input int n, input logic [7:0] tx [12], output logic [7:0] rx [12]);
      cs_b = 1'b0;
      #24;
      for (int k = 0; k < n; k++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi = tx[k][b];
            #24;
            sck = 1'b1;
            rx[k][b] = miso_oe ? miso_o : 1'bx;
            #24;
            sck = 1'b0;
         end
      end
      #24;
      // Released line shows the inverse
      mosi = ~mosi;
      cs_b = 1'b1;
      #48;
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

//--- test/eeprom_cfg_safety_volatile_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module eeprom_cfg_safety_volatile_regs_bench;
   logic clock = 1'b0;
   logic rst_b;
   logic sck, cs_b, mosi, miso_o, miso_oe;
   logic busy = 1'b0, wel = 1'b0, swa = 1'b0, err = 1'b0;
   logic [7:0] status_in = 8'h00;
   logic [10:0] ev = 11'h000;
   logic [1:0] drive_strength;
   logic idpage_lock, buffer_mode_on, buffer_full, pp_decode_allow, status_wr_pulse;
   logic [7:0] safety_flags, status_view, status_wr_data;
   logic [7:0] tx [12];
   logic [7:0] rx [12];
   logic [31:0] seed = 32'hA0206F9C;
   logic [7:0] sf_m = 8'h00, sw_m = 8'h00;
   logic [1:0] drv_m = 2'h1;
   logic lock_m = 1'b0, bon_m = 1'b0, bfl_m = 1'b1;
   int fail_count = 0;
   int comparisons = 0;
   int wr_pulses = 0;
   int pulses_m = 0;
   int wn [5] = '{2, 3, 3, 4, 3};
   logic wok [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
   logic [7:0] wb1 [5] = '{8'h9C, 8'h1C, 8'h0C, 8'h88, 8'h00};
   logic [7:0] wb2 [5] = '{8'h40, 8'h40, 8'h21, 8'h21, 8'h40};
   logic [7:0] sfdp_e [7] = '{8'hFF, 8'hFF, 8'h53, 8'h46, 8'h44, 8'h50, 8'h06};
   always #5 clock = ~clock;
   // one pulse per accepted first byte
   always @(posedge clock) begin
      if (status_wr_pulse) wr_pulses++;
   end
   spi_host_model i_host (.sck(sck), .cs_b(cs_b), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
   eeprom_cfg_safety_volatile_regs i_dut (
      .clock(clock), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe), .busy(busy), .wel(wel),
      .status_wr_allowed(swa), .status_in(status_in), .pu_result_valid(ev[0]),
      .pu_result_err(err), .sw_reset(ev[1]), .protect_violation(ev[2]), .erase_done(ev[3]),
      .erase_err(err), .prog_done(ev[4]), .prog_err(err), .op_start(ev[5]), .ecc_single(ev[6]),
      .ecc_double(ev[7]), .ecc_triple(ev[8]), .buf_taken(ev[9]), .buf_freed(ev[10]),
      .drive_strength(drive_strength), .idpage_lock(idpage_lock), .buffer_mode_on(buffer_mode_on),
      .buffer_full(buffer_full), .pp_decode_allow(pp_decode_allow), .safety_flags(safety_flags),
      .status_view(status_view), .status_wr_pulse(status_wr_pulse), .status_wr_data(status_wr_data)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   // Settle time covers the event sync into the core clock
   task automatic spi(input int n);
      i_host.frame(n, tx, rx);
      repeat (12) @(posedge clock);
   endtask : spi
   task automatic read_regs();
      tx[0] = eeprom_regs_pkg::OP_READ_CFG_SAFETY;
      spi(5);
      for (int k = 1; k < 5; k += 2) begin
         check(rx[k] & 8'h61, {1'b0, drv_m, 4'h0, lock_m});
         check(rx[k + 1], sf_m);
      end
      tx[0] = eeprom_regs_pkg::OP_READ_VOLATILE;
      spi(3);
      for (int k = 1; k < 3; k++) check(rx[k] & 8'h03, {6'h00, bon_m, bfl_m});
      check({5'h00, drive_strength, idpage_lock}, {5'h00, drv_m, lock_m});
   endtask : read_regs
   task automatic vol_wr(input logic w, input logic [7:0] d);
      wel <= w;
      tx[0] = eeprom_regs_pkg::OP_WRITE_VOLATILE;
      tx[1] = d;
      spi(2);
      if (w) begin
         bon_m = d[1];
         bfl_m = ~d[1];
      end
      read_regs();
   endtask : vol_wr
   task automatic pulse(input int i, input logic e);
      @(posedge clock);
      ev[i] <= 1'b1;
      err <= e;
      status_in <= seed[31:24];
      busy <= seed[9];
      @(posedge clock);
      ev[i] <= 1'b0;
      case (i)
         0: sf_m[6] = e;
         1: begin
            sf_m = sf_m & 8'h40;
            bon_m = 1'b0;
            bfl_m = 1'b1;
         end
         2: sf_m[7] = 1'b1;
         3: sf_m[5] = e;
         4: sf_m[4] = e | (bon_m & sf_m[4]);
         5: sf_m[3:1] = 3'h0;
         6: sf_m[3] = 1'b1;
         7: sf_m[2] = 1'b1;
         8: sf_m[1:0] = 2'h3;
         9: bfl_m = 1'b1;
         default: bfl_m = ~bon_m;
      endcase
      @(negedge clock);
      check(safety_flags, sf_m);
      check(status_view, sf_m[6] ? 8'hFF : status_in);
      check({6'h00, buffer_mode_on, buffer_full}, {6'h00, bon_m, bfl_m});
      check({7'h00, pp_decode_allow}, {7'h00, !busy || (bon_m && !bfl_m)});
   endtask : pulse
   initial begin
      // Driven at time zero so the link-side flops see a reset edge
      rst_b <= 1'b0;
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      read_regs();
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         swa <= wok[i];
         wel <= wok[i];
         tx[0] = eeprom_regs_pkg::OP_WRITE_STATUS_CFG;
         tx[1] = wb1[i];
         tx[2] = wb2[i];
         tx[3] = 8'h5D;
         spi(wn[i]);
         if (wok[i]) begin
            sw_m = wb1[i];
            pulses_m++;
            if (wn[i] > 2) begin
               drv_m = wb2[i][6:5];
               lock_m = lock_m | wb2[i][0];
            end
         end
         check(status_wr_data, sw_m);
         read_regs();
      end
      check(wr_pulses[7:0], pulses_m[7:0]);
      $display("test status writes done");
      vol_wr(1'b0, 8'h02);
      vol_wr(1'b1, 8'h02);
      pulse(9, 1'b0);
      pulse(10, 1'b0);
      pulse(4, 1'b1);
      pulse(4, 1'b0);
      vol_wr(1'b1, 8'h00);
      vol_wr(1'b1, 8'hFE);
      $display("test buffer mode done");
      for (int i = 0; i < 11; i++) pulse(i, 1'b1);
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         pulse(seed[15:0] % 11, seed[16]);
      end
      read_regs();
      tx[0] = eeprom_regs_pkg::OP_CLEAR_FLAGS;
      spi(1);
      sf_m = 8'h00;
      check(safety_flags, sf_m);
      read_regs();
      $display("test safety flags done");
      tx[0] = eeprom_regs_pkg::OP_READ_SFDP;
      tx[1] = 8'h00;
      tx[2] = 8'h01;
      tx[3] = 8'hFE;
      tx[4] = 8'h00;
      spi(12);
      for (int k = 0; k < 7; k++) check(rx[k + 5], sfdp_e[k]);
      $display("test table read done");
      end_sim();
   end
   initial begin
      #900000;
      fail_count++;
      end_sim();
   end
endmodule : eeprom_cfg_safety_volatile_regs_bench
`default_nettype wire
